// ==== hdl/fdia_defs.vh ====
`ifndef FDIA_DEFS_VH
`define FDIA_DEFS_VH

// ****************************************
// Window and buffer geometry
// ****************************************
`define FDIA_WIN_BITS    20
`define FDIA_SRAM_WORDS  128
`define FDIA_SRAM_AW     7
`define FDIA_PAGE_BYTES  256
`define FDIA_CNT_W       32

// ****************************************
// Access size codes
// ****************************************
`define FDIA_SZ_BYTE     2'h0
`define FDIA_SZ_HALF     2'h1
`define FDIA_SZ_WORD     2'h2

// ****************************************
// Operation types held in the queue
// ****************************************
`define FDIA_OP_RD       1'b0
`define FDIA_OP_WR       1'b1

// ****************************************
// Flash port states, one-hot
// ****************************************
`define FDIA_F_IDLE      5'h01
`define FDIA_F_RBUR      5'h02
`define FDIA_F_WBUR      5'h04
`define FDIA_F_DRD       5'h08
`define FDIA_F_DWR       5'h10

`endif

// ==== hdl/fdia_sram.v ====
`timescale 1ns/1ps
`include "fdia_defs.vh"

module fdia_sram
#(
    parameter DW    = 32,
    parameter DEPTH = `FDIA_SRAM_WORDS,
    parameter AW    = `FDIA_SRAM_AW
)
(
    input  wire          mclk,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_idx,
    input  wire [DW-1:0] wr_data,
    input  wire [AW-1:0] rd_idx,
    output wire [DW-1:0] rd_data
);

// ****************************************
// Word storage, one flop row per entry
// ****************************************
wire [DW-1:0] row [0:DEPTH-1];

genvar gi;
generate
    for (gi = 0; gi < DEPTH; gi = gi + 1)
    begin : g_row
        reg [DW-1:0] word_ff;
        always @(posedge mclk)
        begin
            if (wr_en && (wr_idx == gi))
                word_ff <= wr_data;
        end
        assign row[gi] = word_ff;
    end
endgenerate

assign rd_data = row[rd_idx];

endmodule // fdia_sram

// ==== hdl/fdia_opq.v ====
`timescale 1ns/1ps
`include "fdia_defs.vh"

module fdia_opq
#(
    parameter W = 65
)
(
    input  wire         mclk,
    input  wire         reset_n,
    input  wire         push,
    input  wire [W-1:0] push_data,
    input  wire         pop,
    output wire         head_valid,
    output wire [W-1:0] head_data,
    output wire         full
);

// ****************************************
// Two-deep queue: active plus one pending
// ****************************************
reg         v0_ff;
reg         v1_ff;
reg [W-1:0] d0_ff;
reg [W-1:0] d1_ff;

always @(posedge mclk)
begin
    if (!reset_n)
    begin
        v0_ff <= 1'b0;
        v1_ff <= 1'b0;
        d0_ff <= {W{1'b0}};
        d1_ff <= {W{1'b0}};
    end
    else if (pop && v0_ff)
    begin
        v0_ff <= v1_ff | push;
        d0_ff <= v1_ff ? d1_ff : push_data;
        v1_ff <= v1_ff & push;
        d1_ff <= push_data;
    end
    else if (push && !v0_ff)
    begin
        v0_ff <= 1'b1;
        d0_ff <= push_data;
    end
    else if (push && !v1_ff)
    begin
        v1_ff <= 1'b1;
        d1_ff <= push_data;
    end
end

assign head_valid = v0_ff;
assign head_data  = d0_ff;
assign full       = v1_ff;

endmodule // fdia_opq

// ==== hdl/fdia_top.v ====
// Summary of operation
// - Direct accesses map into a 1 MB flash window, at zero without remap.
// - Only the low 20 address bits select the byte in the window.
// - With remap enabled every direct access is offset by the remap base.
// - No error is given for addresses beyond the attached flash capacity.
// - Software loads read address and count; read start begins fetching to SRAM.
// - A short final word read returns zeros in unused upper byte lanes.
// - Indirect reads answer at once when data is buffered, else wait.
// - Entries read by the master are freed, lowering the fill level.
// - On a full read partition finish the burst, resume where it stopped.
// - Watermark event when read fill rises past a non-zero read watermark.
// - Watermark event on the final fetched bytes when read watermark non-zero.
// - Outside the trigger range: direct access if enabled, else error.
// - Cancel of read or write aborts that indirect operation.
// - Software loads write address and count; write start begins programming.
// - Surplus bytes of a short final 32-bit write are dropped.
// - Master writes stall while the write partition is full.
// - Program starts with a page buffered or all remaining bytes buffered.
// - Watermark event when write fill drops below a non-zero write watermark.
// - A second trigger queues behind a running operation and starts after it.
// - A trigger with two operations pending is refused with a reject event.
// - Buffer is 128 words; low part for reads, upper part for writes.
// - Direct accesses are served only when direct access is enabled.
`timescale 1ns/1ps
`include "fdia_defs.vh"

module fdia_top
#(
    parameter PAGE_BYTES = `FDIA_PAGE_BYTES,
    parameter DEPTH      = `FDIA_SRAM_WORDS,
    parameter AW         = `FDIA_SRAM_AW,
    parameter CW         = `FDIA_CNT_W
)
(
    input  wire          mclk,
    input  wire          reset_n,
    input  wire          cfg_direct_en,
    input  wire          cfg_remap_en,
    input  wire [31:0]   remap_base,
    input  wire [31:0]   trig_base,
    input  wire [4:0]    trig_span_log2,
    input  wire [AW:0]   rd_part_words,
    input  wire          rd_start,
    input  wire          rd_cancel,
    input  wire [31:0]   rd_start_addr,
    input  wire [CW-1:0] rd_byte_cnt,
    input  wire [CW-1:0] rd_watermark,
    input  wire          wr_start,
    input  wire          wr_cancel,
    input  wire [31:0]   wr_start_addr,
    input  wire [CW-1:0] wr_byte_cnt,
    input  wire [CW-1:0] wr_watermark,
    input  wire          ds_req,
    input  wire          ds_write,
    input  wire [31:0]   ds_addr,
    input  wire [1:0]    ds_size,
    input  wire [31:0]   ds_wdata,
    output wire          ds_ack,
    output wire          ds_err,
    output wire [31:0]   ds_rdata,
    output wire          fl_req,
    output wire          fl_write,
    output wire [31:0]   fl_addr,
    output wire [CW-1:0] fl_len,
    input  wire          fl_rvalid,
    input  wire [31:0]   fl_rdata,
    output wire          fl_wvalid,
    output wire [31:0]   fl_wdata,
    input  wire          fl_wready,
    output wire          ev_watermark,
    output wire          ev_reject,
    output wire [AW:0]   sram_fill,
    output wire          op_busy,
    output wire          op_is_write
);

localparam [4:0]    F_IDLE  = `FDIA_F_IDLE;
localparam [4:0]    F_RBUR  = `FDIA_F_RBUR;
localparam [4:0]    F_WBUR  = `FDIA_F_WBUR;
localparam [4:0]    F_DRD   = `FDIA_F_DRD;
localparam [4:0]    F_DWR   = `FDIA_F_DWR;
localparam [AW:0]   DEPTH_N = DEPTH;
localparam [CW-1:0] PAGE_N  = PAGE_BYTES;
localparam          QW      = 1 + 32 + CW;

// ****************************************
// Registers
// ****************************************
reg [4:0]    fst_ff,   nxt_fst;
reg          ack_ff,   nxt_ack;
reg          err_ff,   nxt_err;
reg [31:0]   rdata_ff, nxt_rdata;
reg          freq_ff,  nxt_freq;
reg          fwr_ff,   nxt_fwr;
reg [31:0]   faddr_ff, nxt_faddr;
reg [CW-1:0] flen_ff,  nxt_flen;
reg          wval_ff,  nxt_wval;
reg [31:0]   wdat_ff,  nxt_wdat;
reg          wm_ff,    nxt_wm;
reg [AW:0]   widx_ff,  nxt_widx;
reg [AW:0]   ridx_ff,  nxt_ridx;
reg [AW:0]   fill_ff,  nxt_fill;
reg [CW-1:0] got_ff,   nxt_got;
reg [CW-1:0] fet_ff,   nxt_fet;
reg [CW-1:0] beat_ff,  nxt_beat;
reg          abort_ff, nxt_abort;
reg          rej_ff;

// ****************************************
// Operation queue
// ****************************************
wire          q_v;
wire [QW-1:0] q_d;
wire          q_full;
reg           q_pop;
wire          q_push = rd_start | wr_start;
wire [QW-1:0] q_in   = rd_start ? {`FDIA_OP_RD, rd_start_addr, rd_byte_cnt}
                                : {`FDIA_OP_WR, wr_start_addr, wr_byte_cnt};

fdia_opq #(.W(QW)) u_opq
(
    .mclk       (mclk),
    .reset_n    (reset_n),
    .push       (q_push & (~q_full | q_pop)),
    .push_data  (q_in),
    .pop        (q_pop),
    .head_valid (q_v),
    .head_data  (q_d),
    .full       (q_full)
);

wire          op_wr  = q_d[QW-1];
wire [31:0]   op_adr = q_d[QW-2:CW];
wire [CW-1:0] op_cnt = q_d[CW-1:0];
wire          rd_act = q_v & (op_wr == `FDIA_OP_RD);
wire          wr_act = q_v & (op_wr == `FDIA_OP_WR);

// ****************************************
// Buffer partition and storage
// ****************************************
wire [AW:0]   part  = rd_act ? rd_part_words : (DEPTH_N - rd_part_words);
wire [AW:0]   base  = rd_act ? {(AW+1){1'b0}} : rd_part_words;
reg           sr_we;
reg  [AW:0]   sr_wrel;
reg  [31:0]   sr_wd;
wire [AW:0]   sr_wabs = base + sr_wrel;
wire [AW:0]   sr_rabs = base + ridx_ff;
wire [31:0]   sr_rd;

fdia_sram #(.DW(32), .DEPTH(DEPTH), .AW(AW)) u_sram
(
    .mclk    (mclk),
    .wr_en   (sr_we),
    .wr_idx  (sr_wabs[AW-1:0]),
    .wr_data (sr_wd),
    .rd_idx  (sr_rabs[AW-1:0]),
    .rd_data (sr_rd)
);

// ****************************************
// Data slave decode
// ****************************************
wire [31:0]   span_mask = (32'h00000001 << trig_span_log2) - 32'h00000001;
wire          in_trig   = (ds_addr & ~span_mask) == (trig_base & ~span_mask);
wire [31:0]   win_off   = {12'h000, ds_addr[`FDIA_WIN_BITS-1:0]};
wire [31:0]   dir_addr  = (cfg_remap_en ? remap_base : 32'h00000000)
                          + win_off;
wire [2:0]    sz_b      = (ds_size == `FDIA_SZ_BYTE) ? 3'h1 :
                          (ds_size == `FDIA_SZ_HALF) ? 3'h2 : 3'h4;
wire [CW-1:0] rem_m     = op_cnt - got_ff;
wire [2:0]    nb        = (rem_m < {{(CW-3){1'b0}}, sz_b}) ? rem_m[2:0] : sz_b;
wire          req_new   = ds_req & ~ack_ff;

// ****************************************
// Fill and watermark helpers
// ****************************************
wire [CW-1:0] rd_wm     = rd_watermark;
wire [CW-1:0] wr_wm     = wr_watermark;
wire [CW-1:0] fb_old    = {{(CW-AW-3){1'b0}}, fill_ff, 2'h0};
reg  [CW-1:0] fb_new;
wire [CW-1:0] free_b    = {{(CW-AW-3){1'b0}}, part - fill_ff, 2'h0};
wire [CW-1:0] fet_rem   = op_cnt - fet_ff;
wire [CW-1:0] avail_b   = got_ff - fet_ff;
wire [CW-1:0] prog_len  = (fet_rem < PAGE_N) ? fet_rem : PAGE_N;
wire [CW-1:0] rd_len    = (fet_rem < free_b) ? fet_rem : free_b;

// Beats for a byte length, rounded up to whole words
function [CW-1:0] fdia_beats;
    input [CW-1:0] len;
    begin
        fdia_beats = (len >> 2) + {{(CW-1){1'b0}}, (len[1:0] != 2'h0)};
    end
endfunction

// Keeps only the low bytes still owed by a short final read
function [31:0] fdia_lanes;
    input [31:0]   w;
    input [CW-1:0] rem;
    begin
        case (rem)
            1:       fdia_lanes = {24'h000000, w[7:0]};
            2:       fdia_lanes = {16'h0000, w[15:0]};
            3:       fdia_lanes = {8'h00, w[23:0]};
            default: fdia_lanes = w;
        endcase
    end
endfunction

// ****************************************
// Next-state logic
// ****************************************
always @*
begin
    nxt_fst   = fst_ff;
    nxt_ack   = 1'b0;
    nxt_err   = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_freq  = 1'b0;
    nxt_fwr   = fwr_ff;
    nxt_faddr = faddr_ff;
    nxt_flen  = flen_ff;
    nxt_wval  = wval_ff;
    nxt_wdat  = wdat_ff;
    nxt_wm    = 1'b0;
    nxt_widx  = widx_ff;
    nxt_ridx  = ridx_ff;
    nxt_fill  = fill_ff;
    nxt_got   = got_ff;
    nxt_fet   = fet_ff;
    nxt_beat  = beat_ff;
    nxt_abort = abort_ff | (rd_cancel & rd_act) | (wr_cancel & wr_act);
    sr_we     = 1'b0;
    sr_wrel   = widx_ff;
    sr_wd     = fl_rdata;
    q_pop     = 1'b0;

    // Data slave side of indirect transfers and error answers
    if (req_new && in_trig && !(fst_ff[3] || fst_ff[4]))
    begin
        if (!ds_write && rd_act && !abort_ff && fill_ff != {(AW+1){1'b0}})
        begin
            nxt_ack   = 1'b1;
            nxt_rdata = fdia_lanes(sr_rd, rem_m);
            nxt_ridx  = (ridx_ff + 1'b1 == part) ? {(AW+1){1'b0}} : ridx_ff + 1'b1;
            nxt_fill  = fill_ff - 1'b1;
            nxt_got   = got_ff + {{(CW-3){1'b0}}, nb};
        end
        else if (ds_write && wr_act && !abort_ff && fill_ff != part)
        begin
            nxt_ack   = 1'b1;
            sr_we     = 1'b1;
            sr_wd     = ds_wdata;
            nxt_widx  = (widx_ff + 1'b1 == part) ? {(AW+1){1'b0}} : widx_ff + 1'b1;
            nxt_fill  = fill_ff + 1'b1;
            nxt_got   = got_ff + {{(CW-3){1'b0}}, nb};
        end
        else if (ds_write ? !wr_act : !rd_act)
        begin
            nxt_ack = 1'b1;
            nxt_err = 1'b1;
        end
    end
    else if (req_new && !in_trig && !cfg_direct_en)
    begin
        nxt_ack = 1'b1;
        nxt_err = 1'b1;
    end

    // Flash port sequencing
    case (fst_ff)
        F_IDLE:
        begin
            if (req_new && !in_trig && cfg_direct_en)
            begin
                nxt_freq  = 1'b1;
                nxt_fwr   = ds_write;
                nxt_faddr = dir_addr;
                nxt_flen  = {{(CW-3){1'b0}}, sz_b};
                nxt_fst   = ds_write ? F_DWR : F_DRD;
                nxt_wval  = ds_write;
                nxt_wdat  = ds_wdata;
            end
            else if (rd_act && !abort_ff && fet_rem != {CW{1'b0}}
                     && free_b != {CW{1'b0}})
            begin
                nxt_freq  = 1'b1;
                nxt_fwr   = 1'b0;
                nxt_faddr = op_adr + fet_ff;
                nxt_flen  = rd_len;
                nxt_beat  = fdia_beats(rd_len);
                nxt_fet   = fet_ff + rd_len;
                nxt_fst   = F_RBUR;
            end
            else if (wr_act && !abort_ff && fet_rem != {CW{1'b0}}
                     && (avail_b >= PAGE_N || avail_b >= fet_rem))
            begin
                nxt_freq  = 1'b1;
                nxt_fwr   = 1'b1;
                nxt_faddr = op_adr + fet_ff;
                nxt_flen  = prog_len;
                nxt_beat  = fdia_beats(prog_len);
                nxt_fet   = fet_ff + prog_len;
                nxt_fst   = F_WBUR;
            end
            else if (q_v && (abort_ff ||
                     (fet_rem == {CW{1'b0}} && (wr_act || rem_m == {CW{1'b0}}))))
            begin
                q_pop = 1'b1;
            end
        end
        F_RBUR:
        begin
            if (fl_rvalid)
            begin
                nxt_beat = beat_ff - 1'b1;
                if (!abort_ff)
                begin
                    sr_we    = 1'b1;
                    nxt_widx = (widx_ff + 1'b1 == part) ? {(AW+1){1'b0}}
                                                        : widx_ff + 1'b1;
                    nxt_fill = nxt_fill + 1'b1;
                    if (beat_ff == {{(CW-1){1'b0}}, 1'b1}
                        && fet_rem == {CW{1'b0}} && rd_wm != {CW{1'b0}})
                        nxt_wm = 1'b1;
                end
                if (beat_ff == {{(CW-1){1'b0}}, 1'b1})
                    nxt_fst = F_IDLE;
            end
        end
        F_WBUR:
        begin
            if (!wval_ff || fl_wready)
            begin
                nxt_wval = 1'b0;
                if (beat_ff != {CW{1'b0}})
                begin
                    nxt_wval = 1'b1;
                    nxt_wdat = sr_rd;
                    nxt_beat = beat_ff - 1'b1;
                    nxt_ridx = (ridx_ff + 1'b1 == part) ? {(AW+1){1'b0}}
                                                        : ridx_ff + 1'b1;
                    nxt_fill = nxt_fill - 1'b1;
                end
                else
                    nxt_fst = F_IDLE;
            end
        end
        F_DRD:
        begin
            if (fl_rvalid)
            begin
                nxt_ack   = 1'b1;
                nxt_rdata = fl_rdata;
                nxt_fst   = F_IDLE;
            end
        end
        F_DWR:
        begin
            if (fl_wready)
            begin
                nxt_wval = 1'b0;
                nxt_ack  = 1'b1;
                nxt_fst  = F_IDLE;
            end
        end
        default:
        begin
            nxt_fst = F_IDLE;
        end
    endcase

    // Read watermark on rising fill, write watermark on falling fill
    fb_new = {{(CW-AW-3){1'b0}}, nxt_fill, 2'h0};
    if (rd_act && rd_wm != {CW{1'b0}} && fb_old <= rd_wm && fb_new > rd_wm)
        nxt_wm = 1'b1;
    if (wr_act && wr_wm != {CW{1'b0}} && fb_old >= wr_wm && fb_new < wr_wm)
        nxt_wm = 1'b1;

    // Fresh pointers and counts for the next queued operation
    if (q_pop)
    begin
        nxt_widx  = {(AW+1){1'b0}};
        nxt_ridx  = {(AW+1){1'b0}};
        nxt_fill  = {(AW+1){1'b0}};
        nxt_got   = {CW{1'b0}};
        nxt_fet   = {CW{1'b0}};
        nxt_abort = 1'b0;
    end
end

// ****************************************
// State registers
// ****************************************
always @(posedge mclk)
begin
    if (!reset_n)
    begin
        fst_ff   <= F_IDLE;
        ack_ff   <= 1'b0;
        err_ff   <= 1'b0;
        rdata_ff <= 32'h00000000;
        freq_ff  <= 1'b0;
        fwr_ff   <= 1'b0;
        faddr_ff <= 32'h00000000;
        flen_ff  <= {CW{1'b0}};
        wval_ff  <= 1'b0;
        wdat_ff  <= 32'h00000000;
        wm_ff    <= 1'b0;
        widx_ff  <= {(AW+1){1'b0}};
        ridx_ff  <= {(AW+1){1'b0}};
        fill_ff  <= {(AW+1){1'b0}};
        got_ff   <= {CW{1'b0}};
        fet_ff   <= {CW{1'b0}};
        beat_ff  <= {CW{1'b0}};
        abort_ff <= 1'b0;
        rej_ff   <= 1'b0;
    end
    else
    begin
        fst_ff   <= nxt_fst;
        ack_ff   <= nxt_ack;
        err_ff   <= nxt_err;
        rdata_ff <= nxt_rdata;
        freq_ff  <= nxt_freq;
        fwr_ff   <= nxt_fwr;
        faddr_ff <= nxt_faddr;
        flen_ff  <= nxt_flen;
        wval_ff  <= nxt_wval;
        wdat_ff  <= nxt_wdat;
        wm_ff    <= nxt_wm;
        widx_ff  <= nxt_widx;
        ridx_ff  <= nxt_ridx;
        fill_ff  <= nxt_fill;
        got_ff   <= nxt_got;
        fet_ff   <= nxt_fet;
        beat_ff  <= nxt_beat;
        abort_ff <= nxt_abort;
        rej_ff   <= (q_push & q_full & ~q_pop) | (rd_start & wr_start);
    end
end

// ****************************************
// Outputs
// ****************************************
assign ds_ack       = ack_ff;
assign ds_err       = err_ff;
assign ds_rdata     = rdata_ff;
assign fl_req       = freq_ff;
assign fl_write     = fwr_ff;
assign fl_addr      = faddr_ff;
assign fl_len       = flen_ff;
assign fl_wvalid    = wval_ff;
assign fl_wdata     = wdat_ff;
assign ev_watermark = wm_ff;
assign ev_reject    = rej_ff;
assign sram_fill    = fill_ff;
assign op_busy      = q_v;
assign op_is_write  = op_wr;

endmodule // fdia_top

// ==== tb/fdia_monitor.sv ====
`timescale 1ns/1ps
// ****************************
// Checks on the top-level ports
// ****************************
module fdia_monitor
#(
    parameter PAGE_BYTES = 8
)
(
    input wire        mclk,
    input wire        reset_n,
    input wire        cfg_direct_en,
    input wire        cfg_remap_en,
    input wire [31:0] remap_base,
    input wire [31:0] trig_base,
    input wire [4:0]  trig_span_log2,
    input wire        ds_req,
    input wire [31:0] ds_addr,
    input wire        ds_ack,
    input wire        ds_err,
    input wire        fl_req,
    input wire        fl_write,
    input wire [31:0] fl_addr,
    input wire [31:0] fl_len,
    input wire        fl_wvalid,
    input wire [31:0] fl_wdata,
    input wire        fl_wready,
    input wire        rd_start,
    input wire        wr_start,
    input wire [31:0] rd_watermark,
    input wire [31:0] wr_watermark,
    input wire        ev_watermark,
    input wire        ev_reject,
    input wire        op_busy
);
    wire [32:0] trig_end = {1'h0, trig_base} + (33'h1 << trig_span_log2);
    wire        in_rng   = ds_addr >= trig_base && {1'h0, ds_addr} < trig_end;
    wire [31:0] dir_addr = (cfg_remap_en ? remap_base : 32'h0) + {12'h0, ds_addr[19:0]};

    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // New direct request while no indirect work holds the flash port
    sequence s_dir_take;
        $rose(ds_req) && !in_rng && cfg_direct_en && !op_busy;
    endsequence

    a_err_with_ack: assert property (ds_err |-> ds_ack)
        else $error("error flag without acknowledge");
    a_direct_addr: assert property (s_dir_take |=> fl_req && fl_addr == $past(dir_addr))
        else $error("direct flash address wrong");
    a_direct_no_err: assert property (s_dir_take |=> ##[0:60] (ds_ack && !ds_err))
        else $error("direct access not answered cleanly");
    a_direct_off_err: assert property ($rose(ds_req) && !in_rng && !cfg_direct_en |=> ds_ack && ds_err)
        else $error("disabled direct access not refused");
    a_reject_both: assert property (rd_start && wr_start |=> ev_reject)
        else $error("coincident triggers not rejected");
    a_wm_disabled: assert property (ev_watermark |-> $past(rd_watermark) | $past(wr_watermark))
        else $error("watermark event while disabled");
    a_wvalid_holds: assert property (fl_wvalid && !fl_wready |=> fl_wvalid && $stable(fl_wdata))
        else $error("write word dropped before taken");
    a_page_burst: assert property (fl_req && fl_write |-> fl_len <= PAGE_BYTES && fl_len != 0)
        else $error("program burst longer than a page");
endmodule // fdia_monitor

bind fdia_top fdia_monitor #(.PAGE_BYTES(PAGE_BYTES)) mon (.*);

// ==== tb/fdia_flash_model.sv ====
`timescale 1ns/1ps
// ****************************
// Flash side of the burst port
// ****************************
module fdia_flash_model
(
    input  wire         mclk,
    input  wire         reset_n,
    input  wire         slow,
    input  wire         fl_req,
    input  wire         fl_write,
    input  wire  [31:0] fl_addr,
    input  wire  [31:0] fl_len,
    input  wire         fl_wvalid,
    input  wire  [31:0] fl_wdata,
    output logic        fl_rvalid,
    output logic [31:0] fl_rdata,
    output wire         fl_wready
);
    logic [31:0] mem [0:63];
    logic [31:0] ptr, left;
    logic        wr, tgl;

    // Slow mode skips every other read beat and holds off write words
    assign fl_wready = wr && left != 32'h0 && !slow;

    always @(posedge mclk)
    begin
        tgl       <= !tgl;
        fl_rvalid <= 1'h0;
        fl_rdata  <= ~fl_rdata;
        if (!reset_n)
            {tgl, wr, left, fl_rdata} <= 66'h0;
        else if (fl_req)
            {ptr, left, wr} <= {fl_addr, (fl_len + 32'h3) >> 2, fl_write};
        else if (fl_wready && fl_wvalid)
        begin
            mem[ptr[7:2]] <= fl_wdata;
            {ptr, left}   <= {ptr + 32'h4, left - 32'h1};
        end
        else if (!wr && left != 32'h0 && !(slow && tgl))
        begin
            {fl_rvalid, fl_rdata} <= {1'h1, ptr ^ 32'hA5A5_0000};
            {ptr, left}           <= {ptr + 32'h4, left - 32'h1};
        end
    end
endmodule // fdia_flash_model

// ==== tb/tb_fdia_top.sv ====
`timescale 1ns/1ps
`include "fdia_defs.vh"
// *********************
// Top-level test bench
// *********************
module tb_fdia_top;
    logic        mclk, reset_n, cfg_direct_en, cfg_remap_en, slow, ds_req, ds_write, e;
    logic        rd_start, wr_start, rd_cancel, wr_cancel;
    logic [31:0] remap_base, trig_base, rd_start_addr, rd_byte_cnt, rd_watermark, q;
    logic [31:0] wr_start_addr, wr_byte_cnt, wr_watermark, ds_addr, ds_wdata, wr_len;
    logic [7:0]  rd_part_words;
    logic [4:0]  trig_span_log2;
    logic [1:0]  ds_size;
    wire         ds_ack, ds_err, fl_req, fl_write, fl_rvalid, fl_wvalid, fl_wready;
    wire         ev_watermark, ev_reject, op_busy, op_is_write;
    wire  [31:0] ds_rdata, fl_addr, fl_len, fl_rdata, fl_wdata;
    wire  [7:0]  sram_fill;
    int          n_fail = 0, cmp_count = 0, n_wm = 0, n_rej = 0, r0, r1;

    fdia_top #(.PAGE_BYTES(8)) uut (.*);
    fdia_flash_model flash (.*);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic ds(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k = 0;
        @(posedge mclk);
        {ds_req, ds_write, ds_addr, ds_wdata} <= {1'h1, w, a, d};
        do @(negedge mclk); while (ds_ack !== 1'h1 && ++k < 500);
        chk({31'h0, ds_ack}, 32'h1);
        {q, e} = {ds_rdata, ds_err};
        @(posedge mclk);
        ds_req <= 1'h0;
    endtask

    task automatic go(input logic [3:0] s);
        @(posedge mclk) {rd_start, wr_start, rd_cancel, wr_cancel} <= s;
        @(posedge mclk) {rd_start, wr_start, rd_cancel, wr_cancel} <= 4'h0;
    endtask

    task automatic idle;
        int k = 0;
        do @(negedge mclk); while (op_busy !== 1'h0 && ++k < 3000);
        chk({31'h0, op_busy}, 32'h0);
    endtask

    task automatic t_direct;
        ds(1'h0, 32'hFFF1_2340, 32'h0);
        chk(q, 32'hA5A4_2340);
        @(posedge mclk) cfg_remap_en <= 1'h1;
        ds(1'h0, 32'h0000_0080, 32'h0);
        chk(q, 32'hA595_0080);
        @(posedge mclk) {remap_base, slow} <= {32'hFFF0_0000, 1'h0};
        ds(1'h1, 32'h0000_0040, 32'h1234_5678);
        chk({31'h0, e}, 32'h0);
        chk(flash.mem[16], 32'h1234_5678);
        @(posedge mclk) {cfg_direct_en, slow} <= 2'h1;
        ds(1'h0, 32'h0000_0040, 32'h0);
        chk({31'h0, e}, 32'h1);
        $display("t_direct done");
    endtask

    task automatic t_rd;
        go(4'h8);
        for (int i = 0; i < 6; i++)
        begin
            ds(1'h0, 32'h8000_0000, 32'h0);
            chk(q, i < 5 ? (32'h100 + 4 * i) ^ 32'hA5A5_0000 : 32'h114);
        end
        idle();
        chk({22'h0, sram_fill, op_busy, n_wm != 0}, 32'h1);
        $display("t_rd done");
    endtask

    task automatic t_wr;
        r0 = n_wm;
        go(4'h4);
        for (int i = 0; i < 4; i++)
            ds(1'h1, 32'h8000_0004, 32'hC0DE_0000 + i);
        @(posedge mclk) slow <= 1'h0;
        idle();
        for (int i = 0; i < 3; i++)
            chk(flash.mem[i], 32'hC0DE_0000 + i);
        chk({flash.mem[3][15:0], wr_len[15:0]}, 32'h0003_0006);
        chk({31'h0, n_wm > r0}, 32'h1);
        $display("t_wr done");
    endtask

    task automatic t_queue;
        {r0, r1} = {n_rej, n_wm};
        @(posedge mclk) {rd_byte_cnt, rd_watermark} <= {32'h4, 32'h0};
        go(4'h4);
        go(4'h8);
        go(4'h4);
        repeat (2) @(posedge mclk);
        chk(n_rej, r0 + 1);
        go(4'h1);
        repeat (3) @(negedge mclk);
        chk({30'h0, op_busy, op_is_write}, 32'h2);
        ds(1'h0, 32'h8000_0000, 32'h0);
        chk(q, 32'hA5A5_0100);
        idle();
        go(4'hC);
        go(4'h2);
        idle();
        chk(n_rej, r0 + 2);
        chk({31'h0, op_busy}, 32'h0);
        chk(n_wm, r1);
        $display("t_queue done");
    endtask

    task automatic stop_test;
        $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge mclk)
    begin
        if (ev_watermark === 1'h1) n_wm++;
        if (ev_reject === 1'h1) n_rej++;
        if (fl_req === 1'h1 && fl_write === 1'h1) wr_len = fl_len;
    end

    initial
    begin
        mclk = 1'h0;
        forever #2.5 mclk = ~mclk;
    end

    initial
    begin
        #100000;
        n_fail++;
        $display("Error %0t: watchdog expired", $time);
        stop_test();
    end

    initial
    begin
        {reset_n, cfg_direct_en, cfg_remap_en, slow, ds_req, ds_write} = 6'h14;
        {rd_start, wr_start, rd_cancel, wr_cancel, ds_size} = {4'h0, `FDIA_SZ_WORD};
        {remap_base, trig_base, trig_span_log2} = {32'h0030_0000, 32'h8000_0000, 5'h5};
        {rd_part_words, rd_start_addr, rd_byte_cnt, rd_watermark} = {8'h4, 32'h100, 32'h16, 32'h8};
        {wr_start_addr, wr_byte_cnt, wr_watermark} = {32'h200, 32'hE, 32'hC};
        {ds_addr, ds_wdata} = 64'h0;
        repeat (20) @(posedge mclk);
        reset_n <= 1'h1;
        t_direct();
        t_rd();
        t_wr();
        t_queue();
        stop_test();
    end
endmodule // tb_fdia_top
